// *** rtl/vrd_pkg.sv ***
// constants and layouts shared by the receive and direction control block
package vrd_pkg;
    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IRQ_EN = 8'h04;
    localparam logic [7:0] OFS_IRQ_MAP = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;

    // ------------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------------
    localparam int CTRL_W = 3;
    localparam int CTRL_SYSCON_BIT = 0;
    localparam int CTRL_ROR_BIT = 1;
    localparam int CTRL_AUTOID_BIT = 2;
    localparam int NUM_BR = 4;
    localparam int NUM_SRC = 8;
    localparam int NUM_PCI_INT = 8;
    localparam int MAP_W = 3;
    localparam int NUM_EV = 4;
    localparam int EV_BERR_BIT = 0;
    localparam int EV_RELEASE_BIT = 1;
    localparam int EV_SYSFAIL_BIT = 2;
    localparam int EV_AUTOID_CLK_BIT = 3;
    localparam int SR_BUSY_BIT = 0;
    localparam int SR_BERR_BIT = 1;
    localparam int SR_REQ_LSB = 2;
    localparam int SR_GNT_LSB = 6;
    localparam int SR_REL_BIT = 10;
    localparam int SR_CLK_BIT = 11;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [NUM_SRC-1:0] IRQ_EN_RST = 8'h00;
    localparam logic [NUM_SRC*MAP_W-1:0] IRQ_MAP_RST = 24'h000000;
    localparam logic [NUM_EV-1:0] INT_MASK_RST = 4'h0;

    // ------------------------------------------------------------------
    // synchroniser vector layout
    // ------------------------------------------------------------------
    localparam int SYNC_W = 16;
    localparam int SY_BUSY = 0;
    localparam int SY_BERR = 1;
    localparam int SY_BR = 2;
    localparam int SY_IRQ = 5;
    localparam int SY_SYSFAIL = 13;
    localparam int SY_SYSRST = 14;
    localparam int SY_SYSCLK = 15;
    localparam logic [SYNC_W-1:0] SYNC_RST = 16'h7fff;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_NS = 25;
    localparam int SYSCLK_HALF_NS = 50;
    localparam logic [1:0] SYSCLK_HALF_CYC = 2'((SYSCLK_HALF_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {ARB_IDLE, ARB_GRANT, ARB_HOLD} vrd_arb_t;
endpackage

// *** rtl/vrd_sync.sv ***
// two-stage synchroniser for all pin inputs of the block
`timescale 1ns/1ps
module vrd_sync
    import vrd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    vrd_sync_if.sync_mp sif
);
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
    } vrd_sync_st_t;

    vrd_sync_st_t state_r;
    vrd_sync_st_t state_nxt;

    // first stage feeds only the second stage
    always_comb begin
        state_nxt = state_r;
        state_nxt.s1 = sif.raw;
        state_nxt.s2 = state_r.s1;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= {SYNC_RST, SYNC_RST};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign sif.sync = state_r.s2;
endmodule

// *** rtl/vrd_sync_if.sv ***
// carrier between the top and its input synchroniser
`timescale 1ns/1ps
interface vrd_sync_if;
    import vrd_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] sync;
    modport sync_mp (input raw, output sync);
    modport user_mp (output raw, input sync);
endinterface

// *** rtl/vrd_top.sv ***
// receive-side bus monitoring, interrupt routing and transceiver direction control
`timescale 1ns/1ps
module vrd_top
    import vrd_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WR_DATA_I,
    input wire logic WR_STB_I,
    input wire logic RD_STB_I,
    output logic [DATA_W-1:0] RD_DATA_O,
    output logic IRQ_O,
    input wire logic BUS_BUSY_IN_N_I,
    input wire logic BUS_ERROR_IN_N_I,
    input wire logic [NUM_BR-1:0] BUS_REQUEST_IN_N_I,
    input wire logic [7:1] VME_IRQ_IN_N_I,
    input wire logic SYSTEM_FAILURE_IN_N_I,
    input wire logic SYSTEM_RESET_IN_N_I,
    input wire logic SYSTEM_CLOCK_PIN_I,
    output logic SYSTEM_CLOCK_PIN_O,
    output logic SYSTEM_CLOCK_PIN_OE_O,
    input wire logic OWN_BUS_I,
    input wire logic SLAVE_DRIVE_I,
    output logic BUS_FREE_O,
    output logic BUS_ERROR_O,
    output logic RELEASE_REQ_O,
    output logic [NUM_BR-1:0] BUS_GRANT_O,
    output logic BUS_CLEAR_OUT_N_O,
    output logic [NUM_PCI_INT-1:0] PCI_INT_N_O,
    output logic LOCAL_RESET_OUT_N_O,
    output logic SLAVE_XCVR_DIRECTION_O,
    output logic SYSCON_XCVR_DIRECTION_O
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [NUM_SRC-1:0] irq_en;
        logic [NUM_SRC*MAP_W-1:0] irq_map;
        logic [NUM_EV-1:0] status;
        logic [NUM_EV-1:0] int_mask;
        logic [DATA_W-1:0] rdata;
        vrd_arb_t arb;
        logic [NUM_BR-1:0] grant;
        logic [1:0] cur_lvl;
        logic bclr_n;
        logic [1:0] div_cnt;
        logic sysclk_o;
        logic sysclk_oe;
        logic clk_prev;
        logic berr_prev_n;
        logic sysfail_prev_n;
        logic [NUM_PCI_INT-1:0] pci_int_n;
        logic local_reset_out_n_n;
        logic slave_dir;
        logic release_req;
        logic irq;
    } vrd_state_t;

    localparam vrd_state_t ST_RST = '{
        ctrl: CTRL_RST,
        irq_en: IRQ_EN_RST,
        irq_map: IRQ_MAP_RST,
        status: '0,
        int_mask: INT_MASK_RST,
        rdata: '0,
        arb: ARB_IDLE,
        grant: '0,
        cur_lvl: 2'h0,
        bclr_n: 1'b1,
        div_cnt: 2'h0,
        sysclk_o: 1'b0,
        sysclk_oe: 1'b0,
        clk_prev: 1'b0,
        berr_prev_n: 1'b1,
        sysfail_prev_n: 1'b1,
        pci_int_n: '1,
        local_reset_out_n_n: 1'b0,
        slave_dir: 1'b0,
        release_req: 1'b0,
        irq: 1'b0
    };

    vrd_state_t state_r;
    vrd_state_t state_nxt;

    // ------------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------------
    vrd_sync_if sif ();

    assign sif.raw = {SYSTEM_CLOCK_PIN_I, SYSTEM_RESET_IN_N_I, SYSTEM_FAILURE_IN_N_I,
                      VME_IRQ_IN_N_I, BUS_REQUEST_IN_N_I,
                      BUS_ERROR_IN_N_I, BUS_BUSY_IN_N_I};

    vrd_sync u_sync (
        .clk_i(MCLK_I),
        .rst_b_i(RST_B_I),
        .sif(sif)
    );

    logic busy_n_s;
    logic berr_n_s;
    logic [NUM_BR-1:0] br_n_s;
    logic [NUM_SRC-1:0] src_n_s;
    logic sysrst_n_s;
    logic sysclk_s;

    assign busy_n_s = sif.sync[SY_BUSY];
    assign berr_n_s = sif.sync[SY_BERR];
    assign br_n_s = sif.sync[SY_BR +: NUM_BR];
    assign src_n_s = {sif.sync[SY_IRQ + 1 +: 7], sif.sync[SY_SYSFAIL]};
    assign sysrst_n_s = sif.sync[SY_SYSRST];
    assign sysclk_s = sif.sync[SY_SYSCLK];

    // ------------------------------------------------------------------
    // interrupt routing
    // ------------------------------------------------------------------
    // source 0 is system failure, sources 1 to 7 are the interrupt levels
    logic [NUM_SRC-1:0] src_act;
    logic [NUM_PCI_INT-1:0] route_hit;

    assign src_act = ~src_n_s & state_r.irq_en;

    genvar gj;
    generate
        for (gj = 0; gj < NUM_PCI_INT; gj++) begin : g_route
            always_comb begin
                route_hit[gj] = 1'b0;
                for (int i = 0; i < NUM_SRC; i++) begin
                    if (src_act[i] && (state_r.irq_map[i*MAP_W +: MAP_W] == MAP_W'(gj))) begin
                        route_hit[gj] = 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // level 3 has the highest priority
    function automatic logic [1:0] top_req(input logic [NUM_BR-1:0] req);
        logic [1:0] lvl;
        lvl = 2'h0;
        for (int i = 0; i < NUM_BR; i++) begin
            if (req[i]) begin
                lvl = 2'(i);
            end
        end
        return lvl;
    endfunction

    function automatic logic [NUM_BR-1:0] higher_mask(input logic [1:0] lvl);
        logic [NUM_BR-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_BR; i++) begin
            if (2'(i) > lvl) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic [NUM_BR-1:0] req;
    logic syscon;
    logic release_on_request_mode;
    logic autoid;
    logic drive_syscon;
    logic wr_any;
    logic [NUM_EV-1:0] ev;
    logic [DATA_W-1:0] state_word;
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        state_nxt = state_r;
        req = ~br_n_s;
        syscon = state_r.ctrl[CTRL_SYSCON_BIT];
        release_on_request_mode = state_r.ctrl[CTRL_ROR_BIT];
        autoid = state_r.ctrl[CTRL_AUTOID_BIT];
        drive_syscon = syscon && !autoid;
        wr_any = WR_STB_I;
        ev = '0;
        state_word = '0;
        rd_mux = '0;

        // register writes
        if (wr_any) begin
            case (ADDR_I)
                OFS_CTRL: state_nxt.ctrl = WR_DATA_I[CTRL_W-1:0];
                OFS_IRQ_EN: state_nxt.irq_en = WR_DATA_I[NUM_SRC-1:0];
                OFS_IRQ_MAP: state_nxt.irq_map = WR_DATA_I[NUM_SRC*MAP_W-1:0];
                OFS_INT_MASK: state_nxt.int_mask = WR_DATA_I[NUM_EV-1:0];
                default: ;
            endcase
        end

        // requester: give up the bus once another master asks for it
        state_nxt.release_req = release_on_request_mode && OWN_BUS_I && (|req);

        // events
        state_nxt.berr_prev_n = berr_n_s;
        state_nxt.sysfail_prev_n = src_n_s[0];
        state_nxt.clk_prev = sysclk_s;
        ev[EV_BERR_BIT] = state_r.berr_prev_n && !berr_n_s;
        ev[EV_RELEASE_BIT] = state_nxt.release_req && !state_r.release_req;
        ev[EV_SYSFAIL_BIT] = state_r.sysfail_prev_n && !src_n_s[0];
        ev[EV_AUTOID_CLK_BIT] = autoid && (sysclk_s != state_r.clk_prev);

        // sticky status, a new event wins over a write-one clear
        state_nxt.status = state_r.status;
        if (wr_any && ADDR_I == OFS_STATUS) begin
            state_nxt.status = state_r.status & ~WR_DATA_I[NUM_EV-1:0];
        end
        state_nxt.status = state_nxt.status | ev;
        state_nxt.irq = |(state_nxt.status & state_nxt.int_mask);

        // arbiter, only active as system controller
        case (state_r.arb)
            ARB_IDLE: begin
                state_nxt.grant = '0;
                state_nxt.bclr_n = 1'b1;
                if (syscon && busy_n_s && (|req)) begin
                    state_nxt.cur_lvl = top_req(req);
                    state_nxt.grant = NUM_BR'(1) << top_req(req);
                    state_nxt.arb = ARB_GRANT;
                end
            end
            ARB_GRANT: begin
                if (!busy_n_s) begin
                    state_nxt.grant = '0;
                    state_nxt.arb = ARB_HOLD;
                end else if (!req[state_r.cur_lvl]) begin
                    state_nxt.grant = '0;
                    state_nxt.arb = ARB_IDLE;
                end
            end
            ARB_HOLD: begin
                // ask the owner to leave when a higher level is waiting
                state_nxt.bclr_n = !(|(req & higher_mask(state_r.cur_lvl)));
                if (busy_n_s) begin
                    state_nxt.bclr_n = 1'b1;
                    state_nxt.arb = ARB_IDLE;
                end
            end
            default: begin
                state_nxt.grant = '0;
                state_nxt.bclr_n = 1'b1;
                state_nxt.arb = ARB_IDLE;
            end
        endcase
        if (!syscon) begin
            state_nxt.grant = '0;
            state_nxt.bclr_n = 1'b1;
            state_nxt.arb = ARB_IDLE;
        end

        // bus clear goes out only while its transceiver faces the bus
        if (!drive_syscon) begin
            state_nxt.bclr_n = 1'b1;
        end

        // system clock divider, held low while the pin is an input
        state_nxt.sysclk_oe = drive_syscon;
        if (drive_syscon) begin
            if (state_r.div_cnt == SYSCLK_HALF_CYC - 2'h1) begin
                state_nxt.div_cnt = 2'h0;
                state_nxt.sysclk_o = !state_r.sysclk_o;
            end else begin
                state_nxt.div_cnt = state_r.div_cnt + 2'h1;
            end
        end else begin
            state_nxt.div_cnt = 2'h0;
            state_nxt.sysclk_o = 1'b0;
        end

        state_nxt.slave_dir = SLAVE_DRIVE_I;
        state_nxt.pci_int_n = ~route_hit;
        state_nxt.local_reset_out_n_n = 1'b1;

        // readback; raw interrupt levels are left out on purpose
        state_word[SR_BUSY_BIT] = !busy_n_s;
        state_word[SR_BERR_BIT] = !berr_n_s;
        state_word[SR_REQ_LSB +: NUM_BR] = req;
        state_word[SR_GNT_LSB +: NUM_BR] = state_r.grant;
        state_word[SR_REL_BIT] = state_r.release_req;
        state_word[SR_CLK_BIT] = sysclk_s;
        if (RD_STB_I) begin
            case (ADDR_I)
                OFS_CTRL: rd_mux = DATA_W'(state_r.ctrl);
                OFS_IRQ_EN: rd_mux = DATA_W'(state_r.irq_en);
                OFS_IRQ_MAP: rd_mux = DATA_W'(state_r.irq_map);
                OFS_STATUS: rd_mux = DATA_W'(state_r.status);
                OFS_INT_MASK: rd_mux = DATA_W'(state_r.int_mask);
                OFS_STATE: rd_mux = state_word;
                default: rd_mux = '0;
            endcase
        end
        state_nxt.rdata = rd_mux;

        // incoming system reset clears everything and holds local reset
        if (!sysrst_n_s) begin
            state_nxt = ST_RST;
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_r <= ST_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign RD_DATA_O = state_r.rdata;
    assign IRQ_O = state_r.irq;
    assign BUS_FREE_O = busy_n_s;
    assign BUS_ERROR_O = !berr_n_s;
    assign RELEASE_REQ_O = state_r.release_req;
    assign BUS_GRANT_O = state_r.grant;
    assign BUS_CLEAR_OUT_N_O = state_r.bclr_n;
    assign PCI_INT_N_O = state_r.pci_int_n;
    assign LOCAL_RESET_OUT_N_O = state_r.local_reset_out_n_n;
    assign SLAVE_XCVR_DIRECTION_O = state_r.slave_dir;
    assign SYSCON_XCVR_DIRECTION_O = state_r.sysclk_oe;
    assign SYSTEM_CLOCK_PIN_O = state_r.sysclk_o;
    assign SYSTEM_CLOCK_PIN_OE_O = state_r.sysclk_oe;
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the receive and direction control block
`timescale 1ns/1ps
module tb;
    import vrd_pkg::*;
    typedef struct packed {logic [2:0] src; logic [2:0] pci; logic [7:0] exp_n;} vrd_row_t;
    logic clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic berr_n = 1'b1, fail_n = 1'b1, srst_n = 1'b1, ext_clk = 1'b0;
    logic own = 1'b0, sdrv = 1'b0;
    logic [7:1] virq_n = 7'h7f;
    logic [3:0] want = 4'h0, req_n, gnt;
    logic busy_n, clk_pin, clk_out, clk_oe, irq, free, berr, rel, bclr_n, local_reset_out_n_n, sdir, cdir;
    logic [7:0] pci_n;
    int errors = 0, tests_run = 0, cycles = 0;
    vrd_row_t rows [8] = '{'{3'h0, 3'h7, 8'h7f}, '{3'h1, 3'h0, 8'hfe}, '{3'h2, 3'h3, 8'hf7},
        '{3'h3, 3'h5, 8'hdf}, '{3'h4, 3'h1, 8'hfd}, '{3'h5, 3'h6, 8'hbf},
        '{3'h6, 3'h2, 8'hfb}, '{3'h7, 3'h4, 8'hef}};

    // the clock pin is shared: the block's drive wins while its enable is high
    assign clk_pin = clk_oe ? clk_out : ext_clk;

    vrd_top u_dut (.MCLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WR_DATA_I(wdata),
        .WR_STB_I(wr_stb), .RD_STB_I(rd_stb), .RD_DATA_O(rdata), .IRQ_O(irq),
        .BUS_BUSY_IN_N_I(busy_n), .BUS_ERROR_IN_N_I(berr_n), .BUS_REQUEST_IN_N_I(req_n),
        .VME_IRQ_IN_N_I(virq_n), .SYSTEM_FAILURE_IN_N_I(fail_n), .SYSTEM_RESET_IN_N_I(srst_n),
        .SYSTEM_CLOCK_PIN_I(clk_pin), .SYSTEM_CLOCK_PIN_O(clk_out),
        .SYSTEM_CLOCK_PIN_OE_O(clk_oe), .OWN_BUS_I(own), .SLAVE_DRIVE_I(sdrv),
        .BUS_FREE_O(free), .BUS_ERROR_O(berr), .RELEASE_REQ_O(rel), .BUS_GRANT_O(gnt),
        .BUS_CLEAR_OUT_N_O(bclr_n), .PCI_INT_N_O(pci_n), .LOCAL_RESET_OUT_N_O(local_reset_out_n_n),
        .SLAVE_XCVR_DIRECTION_O(sdir), .SYSCON_XCVR_DIRECTION_O(cdir));

    vrd_bus_model u_far (.clk_i(clk), .want_i(want), .grant_i(gnt), .busy_n_o(busy_n),
        .req_n_o(req_n));

    // ----------------------------------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic src_drive(input logic [2:0] s, input logic v);
        @(posedge clk);
        if (s == 3'h0) fail_n <= v;
        else virq_n[s] <= v;
    endtask

    task automatic wait_gnt();
        for (int n = 0; n < 20 && gnt === 4'h0; n++) begin
            cyc(1);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wr(OFS_IRQ_MAP, 32'(rows[k].pci) << (3 * rows[k].src));
            wr(OFS_IRQ_EN, 32'h0);
            src_drive(rows[k].src, 1'b0);
            cyc(5);
            chk(pci_n, 8'hff);
            wr(OFS_IRQ_EN, 32'h1 << rows[k].src);
            cyc(5);
            chk(pci_n, rows[k].exp_n);
            src_drive(rows[k].src, 1'b1);
            cyc(5);
            chk(pci_n, 8'hff);
        end
        // second reset in mid-run with configuration loaded
        @(posedge clk);
        rst_b <= 1'b0;
        cyc(2);
        chk({pci_n, local_reset_out_n_n, bclr_n, clk_oe}, {8'hff, 3'b010});
        @(posedge clk);
        rst_b <= 1'b1;
        rd(OFS_CTRL, 32'(CTRL_RST));
        rd(OFS_IRQ_EN, 32'(IRQ_EN_RST));
        rd(OFS_IRQ_MAP, 32'(IRQ_MAP_RST));
        rd(OFS_INT_MASK, 32'(INT_MASK_RST));
        wr(8'h20, 32'hffffffff);
        rd(8'h20, 32'h0);
        rd(OFS_STATUS, 32'h0);
        // bus error event, masking and clearing
        wr(OFS_INT_MASK, 32'h1);
        @(posedge clk);
        berr_n <= 1'b0;
        cyc(5);
        chk({berr, irq}, 2'b11);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_STATUS, 32'h1);
        cyc(2);
        chk(irq, 1'b0);
        @(posedge clk);
        berr_n <= 1'b1;
        cyc(3);
        chk(berr, 1'b0);
        // arbitration as system controller
        wr(OFS_CTRL, 32'h1);
        cyc(6);
        chk({cdir, clk_oe}, 2'b11);
        @(posedge clk);
        want <= 4'b1010;
        wait_gnt();
        chk(gnt, 4'b1000);
        cyc(6);
        chk({gnt, free, bclr_n}, 6'b0000_01);
        @(posedge clk);
        want <= 4'b0010;
        wait_gnt();
        chk(gnt, 4'b0010);
        cyc(6);
        @(posedge clk);
        want <= 4'b1010;
        cyc(6);
        chk({gnt, bclr_n}, 5'b0000_0);
        @(posedge clk);
        want <= 4'h0;
        cyc(8);
        chk({free, bclr_n}, 2'b11);
        // board identification: clock pin watched, not driven
        wr(OFS_CTRL, 32'h5);
        wr(OFS_INT_MASK, 32'h8);
        cyc(4);
        chk({clk_oe, cdir}, 2'b00);
        wr(OFS_STATUS, 32'hf);
        cyc(1);
        chk(irq, 1'b0);
        repeat (4) begin
            @(posedge clk);
            ext_clk <= ~ext_clk;
            cyc(3);
        end
        chk(irq, 1'b1);
        rd(OFS_STATUS, 32'h8);
        // release on request
        wr(OFS_CTRL, 32'h2);
        @(posedge clk);
        own <= 1'b1;
        want <= 4'b0100;
        cyc(6);
        chk(rel, 1'b1);
        rd(OFS_STATUS, 32'ha);
        rd(OFS_STATE, 32'h410);
        @(posedge clk);
        own <= 1'b0;
        want <= 4'h0;
        sdrv <= 1'b1;
        cyc(1);
        chk(sdir, 1'b1);
        @(posedge clk);
        sdrv <= 1'b0;
        cyc(1);
        chk(sdir, 1'b0);
        // incoming system reset
        wr(OFS_IRQ_MAP, 32'h0);
        wr(OFS_IRQ_EN, 32'h1);
        src_drive(3'h0, 1'b0);
        cyc(5);
        chk(pci_n, 8'hfe);
        @(posedge clk);
        srst_n <= 1'b0;
        cyc(4);
        chk({local_reset_out_n_n, pci_n}, {1'b0, 8'hff});
        wr(OFS_CTRL, 32'h1);
        @(posedge clk);
        srst_n <= 1'b1;
        fail_n <= 1'b1;
        cyc(5);
        chk(local_reset_out_n_n, 1'b1);
        rd(OFS_IRQ_EN, 32'h0);
        rd(OFS_CTRL, 32'h0);
        test_done();
    end
endmodule

bind vrd_top vrd_checker u_chk (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I),
    .BUS_BUSY_IN_N_I(BUS_BUSY_IN_N_I), .BUS_ERROR_IN_N_I(BUS_ERROR_IN_N_I),
    .BUS_REQUEST_IN_N_I(BUS_REQUEST_IN_N_I), .SYSTEM_RESET_IN_N_I(SYSTEM_RESET_IN_N_I),
    .OWN_BUS_I(OWN_BUS_I), .SLAVE_DRIVE_I(SLAVE_DRIVE_I), .BUS_FREE_O(BUS_FREE_O),
    .BUS_ERROR_O(BUS_ERROR_O), .RELEASE_REQ_O(RELEASE_REQ_O), .BUS_GRANT_O(BUS_GRANT_O),
    .BUS_CLEAR_OUT_N_O(BUS_CLEAR_OUT_N_O), .PCI_INT_N_O(PCI_INT_N_O),
    .LOCAL_RESET_OUT_N_O(LOCAL_RESET_OUT_N_O), .SLAVE_XCVR_DIRECTION_O(SLAVE_XCVR_DIRECTION_O),
    .SYSCON_XCVR_DIRECTION_O(SYSCON_XCVR_DIRECTION_O), .SYSTEM_CLOCK_PIN_O(SYSTEM_CLOCK_PIN_O),
    .SYSTEM_CLOCK_PIN_OE_O(SYSTEM_CLOCK_PIN_OE_O));

// *** testbench/vrd_bus_model.sv ***
// far-side model: other masters that request, take and release the bus
`timescale 1ns/1ps
module vrd_bus_model (
    input wire logic clk_i,
    input wire logic [3:0] want_i,
    input wire logic [3:0] grant_i,
    output logic busy_n_o,
    output logic [3:0] req_n_o
);
    logic have_r = 1'b0;
    logic [1:0] own_r = 2'h0;

    // a master requests until granted, then drops its request and holds busy
    always_ff @(posedge clk_i) begin
        if (!have_r) begin
            for (int i = 0; i < 4; i++) begin
                if (grant_i[i] && want_i[i]) begin
                    have_r <= 1'b1;
                    own_r <= 2'(i);
                end
            end
        end else if (!want_i[own_r]) begin
            have_r <= 1'b0;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            req_n_o[i] = !(want_i[i] && !(have_r && own_r == 2'(i)));
        end
    end

    assign busy_n_o = !have_r;
endmodule

// *** testbench/vrd_checker.sv ***
// port-level assertions for the receive and direction control block
`timescale 1ns/1ps
module vrd_checker
    import vrd_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic BUS_BUSY_IN_N_I,
    input wire logic BUS_ERROR_IN_N_I,
    input wire logic [NUM_BR-1:0] BUS_REQUEST_IN_N_I,
    input wire logic SYSTEM_RESET_IN_N_I,
    input wire logic OWN_BUS_I,
    input wire logic SLAVE_DRIVE_I,
    input wire logic BUS_FREE_O,
    input wire logic BUS_ERROR_O,
    input wire logic RELEASE_REQ_O,
    input wire logic [NUM_BR-1:0] BUS_GRANT_O,
    input wire logic BUS_CLEAR_OUT_N_O,
    input wire logic [NUM_PCI_INT-1:0] PCI_INT_N_O,
    input wire logic LOCAL_RESET_OUT_N_O,
    input wire logic SLAVE_XCVR_DIRECTION_O,
    input wire logic SYSCON_XCVR_DIRECTION_O,
    input wire logic SYSTEM_CLOCK_PIN_O,
    input wire logic SYSTEM_CLOCK_PIN_OE_O
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking dck @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);

    AST_BUS_FREE: assert property (BUS_FREE_O == $past(BUS_BUSY_IN_N_I, 2))
        else $error("bus free does not follow busy input");
    AST_BUS_ERR: assert property (BUS_ERROR_O == !$past(BUS_ERROR_IN_N_I, 2))
        else $error("bus error does not follow error input");
    AST_GRANT_ONE: assert property ($onehot0(BUS_GRANT_O))
        else $error("more than one grant");
    AST_GRANT_CAUSE: assert property ($rose(|BUS_GRANT_O) |->
        (BUS_GRANT_O & ~$past(BUS_REQUEST_IN_N_I, 3)) != 4'h0)
        else $error("grant without request");
    AST_BCLR_HOLD: assert property (!BUS_CLEAR_OUT_N_O |-> BUS_GRANT_O == 4'h0)
        else $error("bus clear while granting");
    AST_RELEASE: assert property (RELEASE_REQ_O |->
        $past(OWN_BUS_I) && $past(BUS_REQUEST_IN_N_I, 3) != 4'hf)
        else $error("release without request");
    AST_LOCAL_RESET_OUT_N: assert property (!$past(SYSTEM_RESET_IN_N_I, 3) |-> !LOCAL_RESET_OUT_N_O)
        else $error("local reset not asserted");
    AST_LOCAL_RESET_OUT_N_CLR: assert property (!LOCAL_RESET_OUT_N_O |->
        BUS_GRANT_O == 4'h0 && PCI_INT_N_O == 8'hff && !SYSTEM_CLOCK_PIN_OE_O)
        else $error("outputs active during local reset");
    AST_SLV_DIR: assert property (LOCAL_RESET_OUT_N_O && $past(LOCAL_RESET_OUT_N_O) |->
        SLAVE_XCVR_DIRECTION_O == $past(SLAVE_DRIVE_I))
        else $error("slave direction wrong");
    AST_SCON_DIR: assert property (SYSCON_XCVR_DIRECTION_O == SYSTEM_CLOCK_PIN_OE_O)
        else $error("syscon direction differs from clock drive");
    AST_BCLR_DIR: assert property (!BUS_CLEAR_OUT_N_O |-> SYSCON_XCVR_DIRECTION_O)
        else $error("bus clear driven while syscon transceiver faces in");
    AST_CLK_IDLE: assert property (!SYSTEM_CLOCK_PIN_OE_O |-> !SYSTEM_CLOCK_PIN_O)
        else $error("clock driven while not enabled");
    AST_CLK_HALF: assert property ($fell(SYSTEM_CLOCK_PIN_O) && SYSTEM_CLOCK_PIN_OE_O |->
        $past(SYSTEM_CLOCK_PIN_O, 2) && !$past(SYSTEM_CLOCK_PIN_O, 3))
        else $error("clock high phase not two cycles");
endmodule
